// File: shared/pfpp_regs.svh
// Constants of the parallel flash program port.
// Assumes inclusion by bare name from the package and the core file.
`ifndef PFPP_REGS_SVH
`define PFPP_REGS_SVH

// Address at which the security register appears in flash access mode
`define PFPP_SEC_ADDR 16'hffff
// Content of an erased cell and of the erased security register
`define PFPP_ERASED_BYTE 8'hff
`define PFPP_SEC_RESET 8'hff
// Default bit positions inside the security register
`define PFPP_LOCK_BIT 0
`define PFPP_CODE_TABLE_READ_INSTRUCTION_BIT 1
`define PFPP_ENC_BIT 2
`define PFPP_GAIN_BIT 7
// Default encoding key for port 0 data, arbitrary
`define PFPP_ENC_KEY 8'h5a
// Default internal flash address width
`define PFPP_MEM_AW 12
// Programming pin level codes
`define PFPP_VPP_LOW 2'h0
`define PFPP_VPP_HIGH 2'h1
`define PFPP_VPP_PROG 2'h2
`define PFPP_VPP_ERASE 2'h3

`endif

// File: shared/pfpp_pkg.sv
// Types of the parallel flash program port.
// Assumes pfpp_regs.svh on the include path.
`include "pfpp_regs.svh"

package pfpp_pkg;

    // Level seen on the programming pin, decoded by the pad
    typedef enum logic [1:0] {
        PFPP_VPP_IS_LOW = 2'h0,
        PFPP_VPP_IS_HIGH = 2'h1,
        PFPP_VPP_IS_PROG = 2'h2,
        PFPP_VPP_IS_ERASE = 2'h3
    } pfpp_vpp_t;

    // Flash access operation selected by the pins
    typedef enum logic [2:0] {
        PFPP_OP_IDLE = 3'h0,
        PFPP_OP_READ = 3'h1,
        PFPP_OP_PVERIFY = 3'h2,
        PFPP_OP_EVERIFY = 3'h3,
        PFPP_OP_PROGRAM = 3'h4,
        PFPP_OP_ERASE = 3'h5,
        PFPP_OP_INHIBIT = 3'h6
    } pfpp_op_t;

    // Pin image, passed through the input synchroniser as one vector
    typedef struct packed {
        logic rst;
        logic ale;
        logic program_store_strobe_n;
        logic sel_a;
        logic sel_b;
        logic sel_c;
        logic sel_d;
        logic ce_n;
        logic oe_n;
        logic [1:0] vpp;
        logic [15:0] addr;
        logic [7:0] data;
    } pfpp_pins_t;

    // Whole state of the port apart from the flash array
    typedef struct packed {
        pfpp_pins_t s1;
        pfpp_pins_t s2;
        pfpp_pins_t s3;
        pfpp_pins_t filt;
        pfpp_op_t op;
        pfpp_op_t op_prev;
        logic [7:0] sec;
        logic [7:0] dout;
        logic doe;
        logic half_gain;
        logic [7:0] core_p0;
        logic [7:0] code_table_read_instruction_data;
    } pfpp_state_t;

endpackage

// File: core/pfpp_port.sv
// Flash access port: pins from an external programmer, flash array,
// security register and the code-read gate seen by the processor core.
// Assumes pins are asynchronous to mclk_in and that the pad decodes the
// programming pin into a two-bit level code.
`timescale 1ns/1ps
`default_nettype none
`include "pfpp_regs.svh"

module pfpp_port
    import pfpp_pkg::*;
#(
    parameter int MEM_AW = `PFPP_MEM_AW,
    parameter int LOCK_BIT = `PFPP_LOCK_BIT,
    parameter int CODE_TABLE_READ_INSTRUCTION_BIT = `PFPP_CODE_TABLE_READ_INSTRUCTION_BIT,
    parameter int ENC_BIT = `PFPP_ENC_BIT,
    parameter int GAIN_BIT = `PFPP_GAIN_BIT,
    parameter logic [7:0] ENC_KEY = `PFPP_ENC_KEY
) (
    input wire logic mclk_in, // 100 MHz clock
    input wire logic resetn_in, // Async reset, active low
    input wire logic rst_pin_in, // Reset pin, high in flash mode
    input wire logic ale_in, // Address latch strobe pin
    input wire logic program_store_strobe_n_in, // Program store strobe
    input wire logic erase_select_input_in, // Control select A
    input wire logic control_select_b_in, // Control select B
    input wire logic control_select_c_in, // Control select C
    input wire logic control_select_d_in, // Control select D
    input wire logic chip_select_n_in, // Chip select, active low
    input wire logic output_enable_n_in, // Output enable, active low
    input wire logic [1:0] external_access_pin_in, // Programming level
    input wire logic [7:0] addr_hi_in, // Port 2, address high byte
    input wire logic [7:0] addr_lo_in, // Port 1, address low byte
    input wire logic [7:0] data_in, // Port 0 input
    output logic [7:0] data_out, // Port 0 output
    output logic data_oe_out, // Port 0 drive enable
    input wire logic [7:0] core_p0_raw_in, // Core data bound for port 0
    output logic [7:0] core_p0_data_out, // Port 0 data, maybe encoded
    input wire logic core_code_table_read_instruction_exec_ext_in, // Code read runs externally
    input wire logic [15:0] core_code_table_read_instruction_addr_in, // Code read address
    output logic core_code_table_read_instruction_flash_ok_out, // Flash may answer code read
    output logic [7:0] core_code_table_read_instruction_data_out, // Flash byte for code read
    output logic osc_half_gain_out // Oscillator gain halved
);

    // ------------------------------------------------------------
    // Decoding
    // ------------------------------------------------------------

    localparam int DEPTH = 1 << MEM_AW;

    // Operation named by the pin levels; leaving flash mode or any of selects B to D wins first
    function automatic pfpp_op_t op_decode(input pfpp_pins_t p);
        logic mode;
        logic others;
        mode = p.rst && !p.ale && p.program_store_strobe_n;
        others = p.sel_b || p.sel_c || p.sel_d;
        op_decode = PFPP_OP_IDLE;
        if (!mode || others) begin
            op_decode = PFPP_OP_IDLE;
        end else if (p.ce_n && p.oe_n) begin
            op_decode = PFPP_OP_INHIBIT;
        end else if (!p.sel_a) begin
            case ({p.ce_n, p.oe_n, p.vpp})
                {2'b00, `PFPP_VPP_HIGH}: op_decode = PFPP_OP_READ;
                {2'b01, `PFPP_VPP_PROG}: op_decode = PFPP_OP_PROGRAM;
                {2'b10, `PFPP_VPP_PROG}: op_decode = PFPP_OP_PVERIFY;
                default: op_decode = PFPP_OP_IDLE;
            endcase
        end else begin
            case ({p.ce_n, p.oe_n, p.vpp})
                {2'b01, `PFPP_VPP_ERASE}: begin
                    if (!p.addr[0] && p.data == `PFPP_ERASED_BYTE) begin
                        op_decode = PFPP_OP_ERASE;
                    end
                end
                {2'b10, `PFPP_VPP_ERASE}: op_decode = PFPP_OP_EVERIFY;
                default: op_decode = PFPP_OP_IDLE;
            endcase
        end
    endfunction

    // Flash address in range of the internal array
    function automatic logic in_flash(input logic [15:0] a);
        in_flash = (a >> MEM_AW) == 16'h0000;
    endfunction

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------

    pfpp_state_t state_q;
    pfpp_state_t state_d;
    logic [7:0] mem [DEPTH];
    pfpp_pins_t pins;
    logic [MEM_AW-1:0] pin_idx;
    logic [MEM_AW-1:0] core_idx;
    logic sec_sel;
    logic locked;
    logic prog_pulse;
    logic erase_pulse;
    logic [7:0] rd_byte;
    logic [7:0] prog_val;
    logic code_table_read_instruction_ok;
    logic [$bits(pfpp_pins_t)-1:0] agree;

    always_comb begin
        pins = '0;
        pins.rst = rst_pin_in;
        pins.ale = ale_in;
        pins.program_store_strobe_n = program_store_strobe_n_in;
        pins.sel_a = erase_select_input_in;
        pins.sel_b = control_select_b_in;
        pins.sel_c = control_select_c_in;
        pins.sel_d = control_select_d_in;
        pins.ce_n = chip_select_n_in;
        pins.oe_n = output_enable_n_in;
        pins.vpp = external_access_pin_in;
        pins.addr = {addr_hi_in, addr_lo_in};
        pins.data = data_in;
    end

    assign pin_idx = state_q.filt.addr[MEM_AW-1:0];
    assign core_idx = core_code_table_read_instruction_addr_in[MEM_AW-1:0];
    assign agree = ~(state_q.s2 ^ state_q.s3);
    assign sec_sel = state_q.filt.addr == `PFPP_SEC_ADDR;
    assign locked = !state_q.sec[LOCK_BIT];
    // One write per entry into program or erase; a held level is one byte
    assign prog_pulse = state_q.op == PFPP_OP_PROGRAM &&
                        state_q.op_prev != PFPP_OP_PROGRAM && !locked;
    assign erase_pulse = state_q.op == PFPP_OP_ERASE &&
                         state_q.op_prev != PFPP_OP_ERASE;

    // Reads see the security byte at all-ones, else the array; lock hides both
    always_comb begin
        rd_byte = `PFPP_ERASED_BYTE;
        if (locked) begin
            rd_byte = `PFPP_ERASED_BYTE;
        end else if (sec_sel) begin
            rd_byte = state_q.sec;
        end else if (in_flash(state_q.filt.addr)) begin
            rd_byte = mem[pin_idx];
        end
    end

    // Programming can only clear bits, never set them
    always_comb begin
        prog_val = `PFPP_ERASED_BYTE;
        if (sec_sel) begin
            prog_val = state_q.sec & state_q.filt.data;
        end else if (in_flash(state_q.filt.addr)) begin
            prog_val = mem[pin_idx] & state_q.filt.data;
        end
    end

    // Code-table read: restriction bit gates only externally run reads
    assign code_table_read_instruction_ok = !core_code_table_read_instruction_exec_ext_in ||
                     state_q.sec[CODE_TABLE_READ_INSTRUCTION_BIT];
    assign core_code_table_read_instruction_flash_ok_out = code_table_read_instruction_ok && in_flash(core_code_table_read_instruction_addr_in);

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------

    always_comb begin
        state_d = state_q;
        // Three stages; a change is taken once stages two and three agree
        state_d.s1 = pins;
        state_d.s2 = state_q.s1;
        state_d.s3 = state_q.s2;
        // Per pin, so a floating data bus cannot hold back address or modes
        state_d.filt = pfpp_pins_t'((state_q.s3 & agree) |
                                    (state_q.filt & ~agree));
        state_d.op = op_decode(state_q.filt);
        state_d.op_prev = state_q.op;
        if (erase_pulse) begin
            state_d.sec = `PFPP_SEC_RESET;
        end else if (prog_pulse && sec_sel) begin
            state_d.sec = prog_val;
        end
        case (state_q.op)
            PFPP_OP_READ, PFPP_OP_PVERIFY, PFPP_OP_EVERIFY: begin
                state_d.doe = 1'b1;
                state_d.dout = rd_byte;
            end
            default: begin
                state_d.doe = 1'b0;
                state_d.dout = `PFPP_ERASED_BYTE;
            end
        endcase
        state_d.half_gain = !state_q.sec[GAIN_BIT];
        state_d.core_p0 = state_q.sec[ENC_BIT] ? core_p0_raw_in :
                          core_p0_raw_in ^ ENC_KEY;
        // The security register is never visible to the core
        state_d.code_table_read_instruction_data = core_code_table_read_instruction_flash_ok_out ? mem[core_idx] :
                            `PFPP_ERASED_BYTE;
    end

    // Power-up reset loads the erased security pattern; a real part keeps
    // it in flash cells, here it lives only while powered
    always_ff @(posedge mclk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            state_q <= '0;
            state_q.sec <= `PFPP_SEC_RESET;
            state_q.dout <= `PFPP_ERASED_BYTE;
            state_q.code_table_read_instruction_data <= `PFPP_ERASED_BYTE;
        end else begin
            state_q <= state_d;
        end
    end

    // Array has no reset: its content is what survives power cycles
    always_ff @(posedge mclk_in) begin
        if (erase_pulse) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem[i] <= `PFPP_ERASED_BYTE;
            end
        end else if (prog_pulse && !sec_sel && in_flash(state_q.filt.addr))
        begin
            mem[pin_idx] <= prog_val;
        end
    end

    assign data_out = state_q.dout;
    assign data_oe_out = state_q.doe;
    assign core_p0_data_out = state_q.core_p0;
    assign core_code_table_read_instruction_data_out = state_q.code_table_read_instruction_data;
    assign osc_half_gain_out = state_q.half_gain;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------

    default clocking cb @(posedge mclk_in);
    endclocking
    default disable iff (!resetn_in);

    sequence s_prog_entry;
        state_q.op != PFPP_OP_PROGRAM ##1 state_q.op == PFPP_OP_PROGRAM;
    endsequence

    sequence s_prog_written;
        !locked && !sec_sel && in_flash(state_q.filt.addr);
    endsequence

    a_read_drives_byte: assert property (
        state_q.op == PFPP_OP_READ |=>
            data_oe_out && data_out == $past(rd_byte, 1))
        else $error("read data not driven");

    a_lock_hides_data: assert property (
        state_q.op == PFPP_OP_READ && locked |=>
            data_out == `PFPP_ERASED_BYTE)
        else $error("locked read leaked data");

    a_oe_high_floats: assert property (
        state_q.op inside {PFPP_OP_PROGRAM, PFPP_OP_ERASE,
                           PFPP_OP_INHIBIT, PFPP_OP_IDLE} |=> !data_oe_out)
        else $error("bus driven with output enable high");

    a_program_stores: assert property (
        s_prog_entry ##0 s_prog_written |=>
            mem[$past(pin_idx, 1)] == $past(prog_val, 1))
        else $error("programmed byte not stored");

    a_erase_sets_all: assert property (
        erase_pulse |=> state_q.sec == `PFPP_SEC_RESET &&
            mem[0] == `PFPP_ERASED_BYTE && data_oe_out == 1'b0)
        else $error("erase left bits cleared");

    a_inhibit_holds: assert property (
        state_q.op == PFPP_OP_INHIBIT |=> $stable(state_q.sec))
        else $error("inhibited chip changed security");

    a_sec_bits_sticky: assert property (
        !erase_pulse |=> (state_q.sec & ~$past(state_q.sec, 1)) == 8'h00)
        else $error("security bit returned to one");

    a_lock_blocks_program: assert property (
        locked && !erase_pulse |=> $stable(state_q.sec))
        else $error("locked chip accepted a write");

    a_code_table_read_instruction_restricted: assert property (
        core_code_table_read_instruction_exec_ext_in && !state_q.sec[CODE_TABLE_READ_INSTRUCTION_BIT] |->
            !core_code_table_read_instruction_flash_ok_out ##1 core_code_table_read_instruction_data_out ==
            `PFPP_ERASED_BYTE)
        else $error("external code read reached flash");

    a_code_table_read_instruction_internal_free: assert property (
        !core_code_table_read_instruction_exec_ext_in && in_flash(core_code_table_read_instruction_addr_in) |->
            core_code_table_read_instruction_flash_ok_out)
        else $error("internal code read refused");

    a_gain_follows_bit: assert property (
        !state_q.sec[GAIN_BIT] ##1 !state_q.sec[GAIN_BIT] |->
            osc_half_gain_out)
        else $error("gain not halved");

    a_mode_pins_needed: assert property (
        !state_q.filt.rst || state_q.filt.ale || !state_q.filt.program_store_strobe_n |=>
            state_q.op == PFPP_OP_IDLE)
        else $error("operation decoded outside flash mode");

    a_everify_drives: assert property (
        state_q.op == PFPP_OP_EVERIFY |=> data_oe_out)
        else $error("erase verify not driven");

    a_sec_read_byte: assert property (
        state_q.op == PFPP_OP_READ && sec_sel && !locked |=>
            data_out == $past(state_q.sec, 1))
        else $error("security byte not returned");

    a_code_table_read_instruction_no_limit: assert property (
        state_q.sec[CODE_TABLE_READ_INSTRUCTION_BIT] && in_flash(core_code_table_read_instruction_addr_in) |->
            core_code_table_read_instruction_flash_ok_out)
        else $error("unrestricted code read refused");

    a_port0_encoded: assert property (
        !state_q.sec[ENC_BIT] |=>
            core_p0_data_out == ($past(core_p0_raw_in, 1) ^ ENC_KEY))
        else $error("port 0 data not encoded");

endmodule // pfpp_port
`default_nettype wire

// File: sim/pfpp_programmer.sv
// Programmer model: drives the flash access pins as one pin image.
// Assumes the bench resolves port 0 from both drive enables.
`timescale 1ns/1ps
`default_nettype none
`include "pfpp_regs.svh"
module pfpp_programmer
    import pfpp_pkg::*;
(
    input wire logic mclk_in, // Bench clock
    output var pfpp_pins_t pins_out, // Pin image seen by the port
    output var logic drive_out // Programmer drives port 0
);
    // ----------------------------------------
    // Pin images
    // ----------------------------------------
    function automatic pfpp_pins_t idle_pins();
        pfpp_pins_t p;
        p = '0;
        p.rst = 1'b1;
        p.program_store_strobe_n = 1'b1;
        p.ce_n = 1'b1;
        p.oe_n = 1'b1;
        p.data = 8'hff;
        return p;
    endfunction

    initial begin
        pins_out = idle_pins();
        drive_out = 1'b0;
    end

    // A bad code of 1 to 6 breaks one mode condition on purpose
    task automatic apply_op(input pfpp_op_t op, input logic [15:0] a,
                            input logic [7:0] d, input int bad);
        pfpp_pins_t p;
        p = idle_pins();
        p.addr = a;
        p.data = d;
        p.ce_n = op inside {PFPP_OP_PVERIFY, PFPP_OP_EVERIFY,
                            PFPP_OP_INHIBIT};
        p.oe_n = !(op inside {PFPP_OP_READ, PFPP_OP_PVERIFY,
                              PFPP_OP_EVERIFY});
        p.sel_a = op inside {PFPP_OP_EVERIFY, PFPP_OP_ERASE};
        case (op)
            PFPP_OP_PVERIFY, PFPP_OP_PROGRAM, PFPP_OP_INHIBIT: p.vpp = 2'h2;
            PFPP_OP_EVERIFY, PFPP_OP_ERASE: p.vpp = 2'h3;
            default: p.vpp = 2'h1;
        endcase
        p.rst = (bad != 1);
        p.ale = (bad == 2);
        p.program_store_strobe_n = (bad != 3);
        p.sel_b = (bad == 4);
        p.sel_c = (bad == 5);
        p.sel_d = (bad == 6);
        @(posedge mclk_in);
        pins_out <= p;
        drive_out <= p.oe_n;
    endtask

    task automatic release_op();
        @(posedge mclk_in);
        pins_out <= idle_pins();
        drive_out <= 1'b0;
    endtask
endmodule // pfpp_programmer
`default_nettype wire

// File: sim/tb_top.sv
// Bench of the flash access port against a byte-level reference model.
// Assumes default parameters of the port (4 KB array).
`timescale 1ns/1ps
`default_nettype none
`include "pfpp_regs.svh"
module tb_top
    import pfpp_pkg::*;
;
    logic mclk_in, resetn_in, pg_drive, doe, core_ok, half_gain;
    logic core_ext_q;
    logic [7:0] float_q, p0_bus, dout, core_raw_q, core_p0, core_data, d;
    logic [15:0] core_addr_q, a;
    logic [7:0] sec_m;
    logic [7:0] mem_m [0:4095];
    logic [31:0] rnd_q;
    pfpp_pins_t pins;
    int fail_count, samples_checked;

    initial begin
        mclk_in = 1'b0;
        forever #5 mclk_in = ~mclk_in;
    end
    // Released port 0 shows a changing pattern, never a held value
    always @(posedge mclk_in) float_q <= float_q + 8'h3b;
    assign p0_bus = doe ? dout : (pg_drive ? pins.data : float_q);

    pfpp_programmer pg (.mclk_in(mclk_in), .pins_out(pins),
        .drive_out(pg_drive));
    pfpp_port dut (.mclk_in(mclk_in), .resetn_in(resetn_in),
        .rst_pin_in(pins.rst), .ale_in(pins.ale),
        .program_store_strobe_n_in(pins.program_store_strobe_n),
        .erase_select_input_in(pins.sel_a),
        .control_select_b_in(pins.sel_b), .control_select_c_in(pins.sel_c),
        .control_select_d_in(pins.sel_d), .chip_select_n_in(pins.ce_n),
        .output_enable_n_in(pins.oe_n), .external_access_pin_in(pins.vpp),
        .addr_hi_in(pins.addr[15:8]), .addr_lo_in(pins.addr[7:0]),
        .data_in(p0_bus), .data_out(dout), .data_oe_out(doe),
        .core_p0_raw_in(core_raw_q), .core_p0_data_out(core_p0),
        .core_code_table_read_instruction_exec_ext_in(core_ext_q),
        .core_code_table_read_instruction_addr_in(core_addr_q),
        .core_code_table_read_instruction_flash_ok_out(core_ok), .core_code_table_read_instruction_data_out(core_data),
        .osc_half_gain_out(half_gain));

    // ----------------------------------------
    // Model and checks
    // ----------------------------------------
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction

    task automatic check(input logic [7:0] got, input logic [7:0] exp,
                         input string what);
        samples_checked++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value at %0t: %s got %h exp %h", $time, what,
                     got, exp);
        end
    endtask

    function automatic logic [7:0] exp_read(input logic [15:0] ad);
        if (!sec_m[`PFPP_LOCK_BIT]) return 8'hff;
        if (ad == `PFPP_SEC_ADDR) return sec_m;
        if (ad >= 16'h1000) return 8'hff;
        return mem_m[ad[11:0]];
    endfunction

    task automatic do_op(input pfpp_op_t op, input logic [15:0] ad,
                         input logic [7:0] dd, input int bad);
        logic rd;
        rd = op inside {PFPP_OP_READ, PFPP_OP_PVERIFY, PFPP_OP_EVERIFY};
        pg.apply_op(op, ad, dd, bad);
        repeat (8) @(posedge mclk_in);
        #1;
        check({7'h00, doe}, {7'h00, rd && bad == 0}, "drive");
        if (rd && bad == 0) check(dout, exp_read(ad), "read data");
        if (bad == 0 && op == PFPP_OP_PROGRAM && sec_m[`PFPP_LOCK_BIT]) begin
            if (ad == `PFPP_SEC_ADDR) sec_m = sec_m & dd;
            else if (ad < 16'h1000) mem_m[ad[11:0]] &= dd;
        end
        if (bad == 0 && op == PFPP_OP_ERASE && !ad[0] && dd == 8'hff) begin
            sec_m = 8'hff;
            foreach (mem_m[i]) mem_m[i] = 8'hff;
        end
        pg.release_op();
        repeat (8) @(posedge mclk_in);
    endtask

    task automatic core_chk(input logic ext, input logic [11:0] ad,
                            input logic [7:0] raw);
        logic ok;
        logic hg;
        logic [7:0] enc;
        ok = !ext || sec_m[`PFPP_CODE_TABLE_READ_INSTRUCTION_BIT];
        hg = !sec_m[`PFPP_GAIN_BIT];
        enc = sec_m[`PFPP_ENC_BIT] ? 8'h00 : `PFPP_ENC_KEY;
        @(posedge mclk_in);
        core_ext_q <= ext;
        core_addr_q <= {4'h0, ad};
        core_raw_q <= raw;
        @(posedge mclk_in);
        #1;
        check({7'h00, core_ok}, {7'h00, ok}, "code read gate");
        check(core_data, ok ? mem_m[ad] : 8'hff, "code read data");
        check(core_p0, raw ^ enc, "port 0 out");
        check({7'h00, half_gain}, {7'h00, hg}, "gain");
    endtask

    task automatic test_end(input string name);
        $display("test %s done", name);
    endtask

    task automatic close_out();
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // ----------------------------------------
    // Sequence
    // ----------------------------------------
    initial begin
        repeat (20000) @(posedge mclk_in);
        fail_count++;
        $display("wrong value at %0t: watchdog expired", $time);
        close_out();
    end

    initial begin
        resetn_in = 1'b0;
        core_ext_q = 1'b0;
        core_addr_q = 16'h0000;
        core_raw_q = 8'h00;
        float_q = 8'h55;
        fail_count = 0;
        samples_checked = 0;
        rnd_q = 32'h02eb;
        sec_m = 8'hff;
        repeat (3) @(posedge mclk_in);
        resetn_in <= 1'b1;
        do_op(PFPP_OP_ERASE, 16'h0000, 8'hff, 0);
        do_op(PFPP_OP_EVERIFY, 16'h0000, 8'h00, 0);
        do_op(PFPP_OP_EVERIFY, 16'h0fff, 8'h00, 0);
        do_op(PFPP_OP_READ, `PFPP_SEC_ADDR, 8'h00, 0);
        test_end("erase");
        for (int i = 0; i < 8; i++) begin
            rnd_q = lfsr(rnd_q);
            a = {4'h0, rnd_q[11:0]};
            do_op(PFPP_OP_PROGRAM, a, rnd_q[19:12], 0);
            do_op(PFPP_OP_PVERIFY, a, 8'h00, 0);
            rnd_q = lfsr(rnd_q);
            do_op(PFPP_OP_PROGRAM, a, rnd_q[7:0], 0);
            do_op(PFPP_OP_READ, a, 8'h00, 0);
            core_chk(rnd_q[20], a[11:0], rnd_q[31:24]);
        end
        test_end("program");
        do_op(PFPP_OP_IDLE, a, 8'h00, 0);
        do_op(PFPP_OP_INHIBIT, a, 8'h00, 0);
        for (int b = 1; b <= 6; b++) begin
            do_op(PFPP_OP_PROGRAM, a, 8'h00, b);
        end
        do_op(PFPP_OP_ERASE, 16'h0001, 8'hff, 0);
        do_op(PFPP_OP_ERASE, 16'h0000, 8'h7f, 0);
        do_op(PFPP_OP_READ, a, 8'h00, 0);
        do_op(PFPP_OP_READ, 16'h2000, 8'h00, 0);
        test_end("refusal");
        d = ~((8'h01 << `PFPP_CODE_TABLE_READ_INSTRUCTION_BIT) | (8'h01 << `PFPP_ENC_BIT) |
              (8'h01 << `PFPP_GAIN_BIT));
        do_op(PFPP_OP_PROGRAM, `PFPP_SEC_ADDR, d, 0);
        do_op(PFPP_OP_PROGRAM, `PFPP_SEC_ADDR, 8'hff, 0);
        do_op(PFPP_OP_READ, `PFPP_SEC_ADDR, 8'h00, 0);
        core_chk(1'b1, a[11:0], 8'ha5);
        core_chk(1'b0, a[11:0], 8'h96);
        test_end("security");
        d = ~(8'h01 << `PFPP_LOCK_BIT);
        do_op(PFPP_OP_PROGRAM, `PFPP_SEC_ADDR, d, 0);
        do_op(PFPP_OP_READ, a, 8'h00, 0);
        do_op(PFPP_OP_READ, `PFPP_SEC_ADDR, 8'h00, 0);
        do_op(PFPP_OP_PROGRAM, a, 8'h00, 0);
        do_op(PFPP_OP_ERASE, 16'h0000, 8'hff, 0);
        do_op(PFPP_OP_READ, a, 8'h00, 0);
        do_op(PFPP_OP_READ, `PFPP_SEC_ADDR, 8'h00, 0);
        test_end("lock");
        close_out();
    end
endmodule // tb_top
`default_nettype wire
